// ---- design/rsm_radio_link.sv ----
// Radio link SPI master behind the SFR port: registers, two byte FIFOs,
// a mode 0 serial shifter and the transceiver control lines.
// Assumes SFR strobes come from the core on MCLK; MISO is asynchronous.
//
// Contract
// - Mask bit 3 blocks rx-full interrupt
// - Mask bit 2 blocks rx-available interrupt
// - Mask bit 1 blocks tx-empty interrupt
// - Mask bit 0 blocks tx-space interrupt
// - Mask register four bits, resets to 0x0F
// - Status bit 3 shows rx FIFO full
// - Status bit 2 shows rx byte waiting
// - Status bits 1,0 show tx empty, space
// - Status register read-only, resets to 0x03
// - Status flags clear when cause goes away
// - Interrupt when any unmasked source active
// - Data write pushes tx, read pops rx
// - Control bit 2 gates transceiver clock
// - Control bit 1 drives active-low select
// - Control bit 0 drives chip enable
// - Control register alone drives these lines
// - First exchange returns transceiver status byte
// - Bytes shift most significant bit first
`timescale 1ns/10ps
`include "rsm_cfg.svh"

module rsm_radio_link (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    output logic RADIO_SCK,
    output logic RADIO_MOSI,
    input wire logic RADIO_MISO,
    output logic RADIO_SEL_B,
    output logic RADIO_ENABLE,
    output logic RADIO_CLOCK_ENABLE_LINE,
    output logic RADIO_LINK_IRQ
);
    import rsm_pkg::*;

    localparam logic [2:0] HALF_LAST = 3'(`RSM_HALF_CYC - 1);
    localparam int XFER_CYC = `RSM_XFER_CYC;

    // Reset image of the whole state
    localparam rsm_state_t RST_ST = '{
        cfg0: `RSM_RST_CFG0,
        mask: `RSM_RST_MASK,
        stat: `RSM_RST_STAT,
        ctrl: `RSM_RST_CTRL,
        irq: 1'b0,
        rdata: `RSM_RST_DATA,
        phase: RSM_IDLE,
        cnt: 3'h0,
        bitn: 3'h0,
        shreg: 8'h00,
        sck: 1'b0,
        mosi: 1'b0
    };

    rsm_state_t st;       // Current state
    rsm_state_t next_st;  // Next state
    logic miso_s;         // Synchronised MISO
    logic tx_wr;          // Data register write strobe
    logic rx_rd;          // Data register read strobe
    logic tx_in_ready;    // Room in transmit FIFO
    logic tx_valid;       // Transmit byte waiting
    logic [7:0] tx_byte;  // Head of transmit FIFO
    logic tx_pop;         // Shifter takes the head byte
    logic [1:0] tx_count; // Transmit fill level
    logic rx_push;        // Received byte complete
    logic rx_in_ready;    // Room in receive FIFO
    logic rx_valid;       // Received byte waiting
    logic [7:0] rx_byte;  // Head of receive FIFO
    logic [7:0] rx_word;  // Byte being pushed
    logic [1:0] rx_count; // Receive fill level
    logic start;          // Exchange begins this cycle
    logic [3:0] flags;    // Live FIFO conditions

    // MISO crosses in through two flops before anything reads it
    rsm_sync2 u_miso_sync (
        .clk(MCLK),
        .rst_b(RST_B),
        .din(RADIO_MISO),
        .dout(miso_s)
    );

    assign tx_wr = SFR_WR && (SFR_ADDR == `RSM_ADDR_DATA);
    assign rx_rd = SFR_RD && (SFR_ADDR == `RSM_ADDR_DATA);

    // Transmit queue; a write while full is dropped by the FIFO
    rsm_fifo #(
        .WIDTH(`RSM_FIFO_WIDTH),
        .DEPTH(`RSM_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk(MCLK),
        .rst_b(RST_B),
        .in_valid(tx_wr),
        .in_ready(tx_in_ready),
        .in_data(SFR_WDATA),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_byte),
        .count(tx_count)
    );

    // Receive queue; a read while empty pops nothing
    rsm_fifo #(
        .WIDTH(`RSM_FIFO_WIDTH),
        .DEPTH(`RSM_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk(MCLK),
        .rst_b(RST_B),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_word),
        .out_valid(rx_valid),
        .out_ready(rx_rd),
        .out_data(rx_byte),
        .count(rx_count)
    );

    // A new exchange waits for room for its answer, so a full receive
    // queue stalls the link instead of losing bytes
    assign start = (st.phase == RSM_IDLE) && tx_valid && rx_in_ready;
    assign tx_pop = start;
    // Last sample of the eighth bit completes the byte
    assign rx_push = (st.phase == RSM_HIGH) && (st.cnt == HALF_LAST) &&
                     (st.bitn == 3'h7);
    assign rx_word = {st.shreg[6:0], miso_s};

    // Live FIFO conditions; flags follow them with no software clear
    always_comb begin
        flags = 4'h0;
        flags[`RSM_BIT_RX_FULL] = !rx_in_ready;
        flags[`RSM_BIT_RX_AVAIL] = rx_valid;
        flags[`RSM_BIT_TX_EMPTY] = (tx_count == 2'h0);
        flags[`RSM_BIT_TX_SPACE] = tx_in_ready;
    end

    // Register writes, reads, status, interrupt and the serial shifter
    always_comb begin
        next_st = st;
        // Register writes; status has no write path
        if (SFR_WR) begin
            case (SFR_ADDR)
                `RSM_ADDR_CFG0: next_st.cfg0 = SFR_WDATA[6:0];
                `RSM_ADDR_MASK: next_st.mask = SFR_WDATA[3:0];
                // Sole source of the transceiver lines
                `RSM_ADDR_CTRL: next_st.ctrl = SFR_WDATA[2:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end
        // Read data; reserved bits read zero
        if (SFR_RD) begin
            case (SFR_ADDR)
                `RSM_ADDR_CFG0: next_st.rdata = {1'b0, st.cfg0};
                `RSM_ADDR_MASK: next_st.rdata = {4'h0, st.mask};
                `RSM_ADDR_STAT: next_st.rdata = {4'h0, st.stat};
                // Empty queue returns a stale head, state untouched
                `RSM_ADDR_DATA: next_st.rdata = rx_byte;
                `RSM_ADDR_CTRL: next_st.rdata = {5'h00, st.ctrl};
                default: next_st.rdata = 8'h00;
            endcase
        end
        next_st.stat = flags;
        // Unmasked sources raise the line
        next_st.irq = |(flags & ~next_st.mask);
        // Mode 0 shifter: MOSI settles while SCK low, MISO taken at end
        // of the high half, just before the slave can change it
        case (st.phase)
            RSM_IDLE: begin
                if (start) begin
                    next_st.shreg = tx_byte;
                    next_st.mosi = tx_byte[7];
                    next_st.bitn = 3'h0;
                    next_st.cnt = 3'h0;
                    next_st.phase = RSM_LOW;
                end
            end
            RSM_LOW: begin
                if (st.cnt == HALF_LAST) begin
                    next_st.cnt = 3'h0;
                    next_st.sck = 1'b1;
                    next_st.phase = RSM_HIGH;
                end else begin
                    next_st.cnt = 3'(st.cnt + 1'b1);
                end
            end
            RSM_HIGH: begin
                if (st.cnt == HALF_LAST) begin
                    // Shift in at bottom, next bit out from top
                    next_st.shreg = rx_word;
                    next_st.mosi = st.shreg[6];
                    next_st.sck = 1'b0;
                    next_st.cnt = 3'h0;
                    next_st.bitn = 3'(st.bitn + 1'b1);
                    next_st.phase = (st.bitn == 3'h7) ? RSM_IDLE : RSM_LOW;
                end else begin
                    next_st.cnt = 3'(st.cnt + 1'b1);
                end
            end
            default: begin
                next_st.phase = RSM_IDLE;
                next_st.sck = 1'b0;
            end
        endcase
    end

    // Register the whole state; synchronous reset
    always_ff @(posedge MCLK) begin
        if (!RST_B) begin
            st <= RST_ST;
        end else begin
            st <= next_st;
        end
    end

    // Every output straight from the state record
    assign SFR_RDATA = st.rdata;
    assign RADIO_SCK = st.sck;
    assign RADIO_MOSI = st.mosi;
    assign RADIO_SEL_B = st.ctrl[`RSM_BIT_CSN];
    assign RADIO_ENABLE = st.ctrl[`RSM_BIT_CE];
    assign RADIO_CLOCK_ENABLE_LINE = st.ctrl[`RSM_BIT_RADIO_CLOCK_ENABLE_LINE];
    assign RADIO_LINK_IRQ = st.irq;

    // Checks on the design's own behaviour
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    // Fresh out of reset: all sources masked, tx empty and ready
    property p_reset_vals;
        $rose(RST_B) |-> st.mask == 4'hF && st.stat == 4'h3 && !st.irq;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("Reset values of mask or status wrong");

    // Interrupt line tracks unmasked status, any of the four sources
    property p_irq_gate;
        RADIO_LINK_IRQ == ((st.stat[3] && !st.mask[3]) ||
            (st.stat[2] && !st.mask[2]) || (st.stat[1] && !st.mask[1]) ||
            (st.stat[0] && !st.mask[0]));
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt does not follow masked status");

    // Receive flags mirror the receive FIFO one cycle later
    property p_rx_flags;
        st.stat[2] == ($past(rx_count) != 2'h0) &&
        st.stat[3] == ($past(rx_count) == 2'h2);
    endproperty
    a_rx_flags: assert property (p_rx_flags)
        else $error("Receive status flags wrong");

    // Transmit flags mirror the transmit FIFO one cycle later
    property p_tx_flags;
        st.stat[1] == ($past(tx_count) == 2'h0) &&
        st.stat[0] == ($past(tx_count) != 2'h2);
    endproperty
    a_tx_flags: assert property (p_tx_flags)
        else $error("Transmit status flags wrong");

    // A data write to an empty queue with no pop grows it by one
    property p_tx_push;
        tx_wr && tx_count == 2'h0 && !tx_pop |=> tx_count == 2'h1;
    endproperty
    a_tx_push: assert property (p_tx_push)
        else $error("Data write did not reach transmit FIFO");

    // A write to a full queue that is not drained this cycle changes
    // nothing; a stalled link is the usual way to get here
    property p_tx_drop;
        tx_wr && tx_count == 2'h2 && !tx_pop
            |=> tx_count == 2'h2 && $stable(tx_byte);
    endproperty
    a_tx_drop: assert property (p_tx_drop)
        else $error("Write to full transmit FIFO not dropped");

    // Control writes land on the three transceiver lines
    property p_ctrl_lines;
        SFR_WR && SFR_ADDR == `RSM_ADDR_CTRL |=>
            RADIO_CLOCK_ENABLE_LINE == $past(SFR_WDATA[2]) &&
            RADIO_SEL_B == $past(SFR_WDATA[1]) &&
            RADIO_ENABLE == $past(SFR_WDATA[0]);
    endproperty
    a_ctrl_lines: assert property (p_ctrl_lines)
        else $error("Control write not seen on transceiver lines");

    // Exchange: first bit is the top bit, answer pushed after 64 cycles
    sequence s_first_bit;
        RADIO_MOSI == $past(tx_byte[7]) && !RADIO_SCK;
    endsequence
    sequence s_answer;
        ##(XFER_CYC - 1) rx_push;
    endsequence
    property p_exchange;
        start |=> s_first_bit and s_answer;
    endproperty
    a_exchange: assert property (p_exchange)
        else $error("Exchange timing or bit order wrong");

    // A full receive queue keeps an idle shifter idle with the clock low
    property p_rx_stall;
        rx_count == 2'h2 && st.phase == RSM_IDLE |=>
            st.phase == RSM_IDLE && !RADIO_SCK;
    endproperty
    a_rx_stall: assert property (p_rx_stall)
        else $error("Exchange started with receive FIFO full");

endmodule : rsm_radio_link

// ---- design/rsm_cfg.svh ----
// Constants of the radio link SPI master: SFR addresses, field positions,
// reset values and link timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RSM_CFG_SVH
`define RSM_CFG_SVH

// SFR addresses of the register port
`define RSM_ADDR_CFG0 8'hE4
`define RSM_ADDR_MASK 8'hE5
`define RSM_ADDR_STAT 8'hE6
`define RSM_ADDR_DATA 8'hE7
`define RSM_ADDR_CTRL 8'hE8

// Reset values
`define RSM_RST_CFG0 7'h01
`define RSM_RST_MASK 4'hF
`define RSM_RST_STAT 4'h3
`define RSM_RST_DATA 8'h00
`define RSM_RST_CTRL 3'h2

// Interrupt mask and status bit positions
`define RSM_BIT_RX_FULL 3
`define RSM_BIT_RX_AVAIL 2
`define RSM_BIT_TX_EMPTY 1
`define RSM_BIT_TX_SPACE 0

// Control register bit positions
`define RSM_BIT_RADIO_CLOCK_ENABLE_LINE 2
`define RSM_BIT_CSN 1
`define RSM_BIT_CE 0

// FIFO shape: two bytes each way
`define RSM_FIFO_WIDTH 8
`define RSM_FIFO_DEPTH 2

// Link timing: core clock period and serial clock period, in ns
`define RSM_MCLK_NS 20
`define RSM_SCK_NS 160
`define RSM_HALF_CYC (`RSM_SCK_NS / `RSM_MCLK_NS / 2)
// Cycles from exchange start to the push of the received byte
`define RSM_XFER_CYC (8 * 2 * `RSM_HALF_CYC)

`endif

// ---- design/rsm_pkg.sv ----
// Types of the radio link SPI master: shifter states and the state record.
// Assumes rsm_cfg.svh is on the include path.
`include "rsm_cfg.svh"

package rsm_pkg;

    // Serial shifter phases
    typedef enum logic [1:0] {
        RSM_IDLE = 2'b00,  // Waiting for a byte and room for the answer
        RSM_LOW = 2'b01,   // Serial clock low, output bit settled
        RSM_HIGH = 2'b10   // Serial clock high, input bit sampled at end
    } rsm_phase_t;

    // Whole state of the top module
    typedef struct packed {
        logic [6:0] cfg0;      // Configuration zero, kept as written
        logic [3:0] mask;      // Interrupt mask
        logic [3:0] stat;      // Status flags
        logic [2:0] ctrl;      // Clock enable, select, chip enable
        logic irq;             // Interrupt line
        logic [7:0] rdata;     // SFR read data
        rsm_phase_t phase;     // Shifter phase
        logic [2:0] cnt;       // Cycles within a half period
        logic [2:0] bitn;      // Bit index within the byte
        logic [7:0] shreg;     // Shift register, out at top, in at bottom
        logic sck;             // Serial clock
        logic mosi;            // Serial data out
    } rsm_state_t;

endpackage : rsm_pkg

// ---- design/rsm_sync2.sv ----
// Two flip-flop synchroniser for one pin level.
// Assumes the input is asynchronous to MCLK; only the second stage is read.
`timescale 1ns/10ps

module rsm_sync2 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic din,
    output logic dout
);
    // Both stages kept in one record
    typedef struct packed {
        logic meta;   // First stage, read only by the second
        logic stab;   // Second stage
    } rsm_sync_t;

    rsm_sync_t st;
    rsm_sync_t next_st;

    // Shift the level one stage per edge
    always_comb begin
        next_st.meta = din;
        next_st.stab = st.meta;
    end

    // Synchronous reset to zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.stab;

endmodule : rsm_sync2

// ---- design/rsm_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides and a fill count.
// Assumes both sides share one clock; full shown by in_ready, empty by out_valid.
`timescale 1ns/10ps

module rsm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH+1);

    // Storage, pointers and fill level in one record
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] count;
    } rsm_fifo_st_t;

    rsm_fifo_st_t st;
    rsm_fifo_st_t next_st;
    logic push;
    logic pop;

    // Pointer advance with wrap at the depth
    function automatic logic [AW-1:0] rsm_adv(input logic [AW-1:0] p);
        rsm_adv = (p == AW'(DEPTH-1)) ? '0 : AW'(p + 1'b1);
    endfunction : rsm_adv

    assign in_ready = (st.count != CW'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rd];
    assign count = st.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Write, read and count update; a push onto a full FIFO is dropped
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = rsm_adv(st.wr);
        end
        if (pop) begin
            next_st.rd = rsm_adv(st.rd);
        end
        // Simultaneous push and pop leaves the level alone
        if (push && !pop) begin
            next_st.count = CW'(st.count + 1'b1);
        end else if (pop && !push) begin
            next_st.count = CW'(st.count - 1'b1);
        end
    end

    // Register the record
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

endmodule : rsm_fifo

// ---- tb/rsm_radio_model.sv ----
// Behavioural transceiver serial slave facing the radio link master.
// Assumes mode 0: master drives MOSI with SCK low, samples MISO at the end of SCK high.
`timescale 1ns/10ps

module rsm_radio_model #(
    parameter logic [7:0] STATUS = 8'h0E  // Arbitrary status byte
) (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_b,
    output logic miso,
    output logic [7:0] last_rx
);
    logic [7:0] outq;  // Byte being shifted out
    logic [7:0] inq;  // Byte being shifted in
    int nbit;  // Bits taken in the current byte

    // Quiet start before the first selection
    initial begin
        miso = 1'b0;
        last_rx = 8'h00;
        outq = 8'h00;
        inq = 8'h00;
        nbit = 0;
    end

    // A new command opens with the status byte going out
    always @(negedge sel_b) begin
        outq = STATUS;
        nbit = 0;
        miso = outq[7];
    end

    // No pull on the line: a released line must not look like stale data
    always @(posedge sel_b) begin
        miso = ~miso;
    end

    // Take one bit per rising edge, most significant first
    always @(posedge sck) begin
        if (!sel_b) begin
            inq = {inq[6:0], mosi};
            nbit++;
        end
    end

    // Next bit on the falling edge; a whole byte is echoed next
    always @(negedge sck) begin
        if (!sel_b) begin
            if (nbit == 8) begin
                last_rx = inq;
                outq = inq;
                nbit = 0;
            end else begin
                outq = {outq[6:0], 1'b0};
            end
            miso = outq[7];
        end
    end
endmodule : rsm_radio_model

// ---- tb/rsm_radio_link_bench.sv ----
// Self-checking bench for the radio link SPI master through its SFR port.
// Assumes rsm_cfg.svh on the include path and the serial slave model.
`timescale 1ns/10ps
`include "rsm_cfg.svh"

module rsm_radio_link_bench;
    logic mclk;  // Core clock, 50 MHz
    logic rst_b;  // Synchronous reset, active low
    logic [7:0] addr;  // SFR address
    logic [7:0] wdata;  // SFR write data
    logic wr;  // Write strobe
    logic rd;  // Read strobe
    logic [7:0] rdata;  // SFR read data
    logic sck;  // Serial clock
    logic mosi;  // Serial data to the slave
    logic miso;  // Serial data from the slave
    logic sel_b;  // Slave select, active low
    logic ena;  // Transceiver enable
    logic radio_clock_enable_line;  // Transceiver clock gate
    logic irq;  // Interrupt line
    logic [7:0] last_rx;  // Last byte seen by the slave
    int bad_count;  // Mismatches
    int checks_done;  // Comparisons

    rsm_radio_link uut (
        .MCLK(mclk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .RADIO_SCK(sck),
        .RADIO_MOSI(mosi), .RADIO_MISO(miso), .RADIO_SEL_B(sel_b),
        .RADIO_ENABLE(ena), .RADIO_CLOCK_ENABLE_LINE(radio_clock_enable_line),
        .RADIO_LINK_IRQ(irq)
    );

    rsm_radio_model partner (
        .sck(sck), .mosi(mosi), .sel_b(sel_b), .miso(miso),
        .last_rx(last_rx)
    );

    // Free running core clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Verdict and end of run, shared with the watchdog
    task automatic finish_test;
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    // Byte comparison
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    // Pin comparison
    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // Idle cycles
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : wait_cyc

    // One-cycle write strobe
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : sfr_wr

    // One-cycle read strobe; data is held, so one spare edge is harmless
    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        #1 d = rdata;
    endtask : sfr_rd

    // Read and compare
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        sfr_rd(a, d);
        chk8(d, exp);
    endtask : rd_chk

    // Write the mask, let status and interrupt settle, check the line
    task automatic irq_chk(input logic [7:0] m, input logic exp);
        sfr_wr(`RSM_ADDR_MASK, m);
        wait_cyc(3);
        chk1(irq, exp);
    endtask : irq_chk

    // Control pins as {clock gate, select, enable}
    task automatic pins(input logic [2:0] e);
        chk1(radio_clock_enable_line, e[2]);
        chk1(sel_b, e[1]);
        chk1(ena, e[0]);
    endtask : pins

    // Hang guard: the whole sequence needs about 600 cycles
    initial begin
        wait_cyc(20000);
        bad_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        logic [7:0] junk;
        bad_count = 0;
        checks_done = 0;
        rst_b = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wait_cyc(4);
        rst_b <= 1'b1;
        wait_cyc(1);
        pins(3'h2);
        rd_chk(`RSM_ADDR_CFG0, 8'h01);
        rd_chk(`RSM_ADDR_MASK, 8'h0F);
        rd_chk(`RSM_ADDR_STAT, 8'h03);
        rd_chk(`RSM_ADDR_CTRL, 8'h02);
        rd_chk(8'hE0, 8'h00);
        sfr_wr(`RSM_ADDR_STAT, 8'hFF);
        rd_chk(`RSM_ADDR_STAT, 8'h03);
        sfr_wr(`RSM_ADDR_MASK, 8'hFF);
        rd_chk(`RSM_ADDR_MASK, 8'h0F);
        // Every control code; reserved bits written high must read low
        for (int i = 0; i < 8; i++) begin
            sfr_wr(`RSM_ADDR_CTRL, {5'h1F, i[2:0]});
            wait_cyc(2);
            pins(i[2:0]);
            rd_chk(`RSM_ADDR_CTRL, {5'h00, i[2:0]});
        end
        // Transmit side sources with an idle, empty queue
        irq_chk(8'h0F, 1'b0);
        irq_chk(8'h0E, 1'b1);
        irq_chk(8'h0D, 1'b1);
        irq_chk(8'h03, 1'b0);
        irq_chk(8'h0F, 1'b0);
        // Select, then command and two payload bytes back to back
        sfr_wr(`RSM_ADDR_CTRL, 8'h05);
        wait_cyc(3);
        sfr_wr(`RSM_ADDR_DATA, 8'h5A);
        sfr_wr(`RSM_ADDR_DATA, 8'h12);
        sfr_wr(`RSM_ADDR_DATA, 8'h34);
        // Two answers fill the receive queue; the third byte must stall
        wait_cyc(200);
        rd_chk(`RSM_ADDR_STAT, 8'h0D);
        chk1(sck, 1'b0);
        sfr_wr(`RSM_ADDR_DATA, 8'h56);
        sfr_wr(`RSM_ADDR_DATA, 8'h77);
        wait_cyc(3);
        rd_chk(`RSM_ADDR_STAT, 8'h0C);
        irq_chk(8'h07, 1'b1);
        irq_chk(8'h0B, 1'b1);
        irq_chk(8'h0E, 1'b0);
        irq_chk(8'h0D, 1'b0);
        irq_chk(8'h0F, 1'b0);
        // Drain; each pop frees room for one more stalled exchange
        rd_chk(`RSM_ADDR_DATA, 8'h0E);
        wait_cyc(100);
        rd_chk(`RSM_ADDR_DATA, 8'h5A);
        wait_cyc(100);
        rd_chk(`RSM_ADDR_DATA, 8'h12);
        rd_chk(`RSM_ADDR_DATA, 8'h34);
        wait_cyc(10);
        rd_chk(`RSM_ADDR_STAT, 8'h03);
        chk8(last_rx, 8'h56);
        // Read from an empty queue leaves the flags alone
        sfr_rd(`RSM_ADDR_DATA, junk);
        wait_cyc(3);
        rd_chk(`RSM_ADDR_STAT, 8'h03);
        sfr_wr(`RSM_ADDR_CTRL, 8'h02);
        wait_cyc(3);
        pins(3'h2);
        finish_test();
    end
endmodule : rsm_radio_link_bench
